// File: logic/fir_host.sv
// Host controller issuing information-read commands to a parallel flash
// Contract
// - Identifier mode lasts until another valid command; host writes one to leave.
// - Host trusts block status only while the ready flag reads 1.
// - Host raises output or chip enable between status reads.
// - Host rewrites multi-word write command to refresh extended status.
// - Info commands ignore program supply; reset/power-down pin must be high.
`timescale 1ns/1ps
module fir_host (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [20:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [15:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic reset_powerdown_bar_o,
    output logic word_mode_o
);
    typedef struct packed {
        fir_pkg::fir_state_t st;
        fir_pkg::fir_mode_t mode;
        fir_pkg::fir_mode_t tgt;
        fir_pkg::fir_op_t op;
        logic [7:0] cnt;
        logic need_rd;
        logic rp;
        logic word;
        logic [20:0] addr;
        logic [20:0] pin_addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [15:0] result;
        logic [7:0] sr;
        logic blk_valid;
        logic ack;
        logic [31:0] rdat;
    } fir_host_t;

    fir_host_t q;
    fir_host_t next_q;
    logic [15:0] dq_sync;

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    fir_sync #(.W(16)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(flash_dq_i),
        .q_o(dq_sync)
    );

    // ------------------------------------------------------------
    // Next-state logic: bus slave and flash cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic start;
        logic need_cmd;
        logic [7:0] cmd;
        fir_pkg::fir_op_t op;
        start = 1'b0;
        need_cmd = 1'b0;
        cmd = fir_pkg::CMD_READ_ARRAY;
        op = fir_pkg::fir_op_t'(wb_dat_i[2:0]);
        next_q = q;
        next_q.ack = 1'b0;
        // Single-cycle wishbone answer, one cycle after the strobe
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            next_q.ack = 1'b1;
            next_q.rdat = 32'h0000_0000;
            if (!wb_we_i) begin
                case (wb_adr_i)
                    fir_pkg::REG_CTRL: next_q.rdat = {30'h0, q.word, q.rp};
                    fir_pkg::REG_OP: next_q.rdat = {29'h0, q.op};
                    fir_pkg::REG_ADDR: next_q.rdat = {11'h0, q.addr};
                    fir_pkg::REG_RESULT: next_q.rdat = {16'h0, q.result};
                    fir_pkg::REG_STATUS: next_q.rdat = {16'h0, q.sr, 3'h0, q.blk_valid,
                                                        q.mode, q.st != fir_pkg::S_IDLE};
                    default: next_q.rdat = 32'h0000_0000;
                endcase
            end else begin
                case (wb_adr_i)
                    fir_pkg::REG_CTRL: begin
                        if (wb_sel_i[0]) begin
                            next_q.rp = wb_dat_i[fir_pkg::CTRL_RP_BIT];
                            next_q.word = wb_dat_i[fir_pkg::CTRL_WORD_BIT];
                        end
                    end
                    fir_pkg::REG_ADDR: begin
                        // Byte lanes; the top lane carries only five address bits
                        if (wb_sel_i[0]) next_q.addr[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) next_q.addr[15:8] = wb_dat_i[15:8];
                        if (wb_sel_i[2]) next_q.addr[20:16] = wb_dat_i[20:16];
                    end
                    fir_pkg::REG_OP: begin
                        // Commands only while idle and the device is out of reset
                        start = wb_sel_i[0] && q.st == fir_pkg::S_IDLE && q.rp;
                    end
                    default: ;
                endcase
            end
        end

        // Flash cycle sequencer
        case (q.st)
            fir_pkg::S_IDLE: begin
                if (start) begin
                    next_q.op = op;
                    next_q.need_rd = 1'b1;
                    next_q.pin_addr = q.addr;
                    next_q.tgt = q.mode;
                    case (op)
                        fir_pkg::OP_ARRAY_READ: begin
                            need_cmd = q.mode != fir_pkg::MODE_ARRAY;
                            cmd = fir_pkg::CMD_READ_ARRAY;
                            next_q.tgt = fir_pkg::MODE_ARRAY;
                        end
                        fir_pkg::OP_ID_READ, fir_pkg::OP_BLOCK_READ: begin
                            // Mode persists, so a repeat skips the command
                            need_cmd = q.mode != fir_pkg::MODE_ID;
                            cmd = fir_pkg::CMD_READ_ID;
                            next_q.tgt = fir_pkg::MODE_ID;
                            if (op == fir_pkg::OP_BLOCK_READ) begin
                                next_q.pin_addr = {q.addr[4:0], fir_pkg::ID_BLOCK_OFS};
                            end
                        end
                        fir_pkg::OP_STATUS_READ: begin
                            need_cmd = q.mode != fir_pkg::MODE_STATUS;
                            cmd = fir_pkg::CMD_READ_STATUS;
                            next_q.tgt = fir_pkg::MODE_STATUS;
                        end
                        fir_pkg::OP_EXT_READ: begin
                            need_cmd = 1'b1;
                            cmd = fir_pkg::CMD_MULTI_WRITE;
                            next_q.tgt = fir_pkg::MODE_EXT;
                        end
                        fir_pkg::OP_CLEAR: begin
                            need_cmd = 1'b1;
                            cmd = fir_pkg::CMD_CLEAR_STATUS;
                            next_q.need_rd = 1'b0;
                        end
                        fir_pkg::OP_QUERY_READ: begin
                            need_cmd = q.mode != fir_pkg::MODE_QUERY;
                            cmd = fir_pkg::CMD_QUERY;
                            next_q.tgt = fir_pkg::MODE_QUERY;
                            next_q.pin_addr = {q.addr[19:0], 1'b0};
                        end
                        default: begin
                            need_cmd = 1'b1;
                            cmd = fir_pkg::CMD_READ_ARRAY;
                            next_q.tgt = fir_pkg::MODE_ARRAY;
                            next_q.need_rd = 1'b0;
                        end
                    endcase
                    next_q.ce_n = 1'b0;
                    if (need_cmd) begin
                        next_q.st = fir_pkg::S_CMD;
                        next_q.we_n = 1'b0;
                        next_q.dq_oe = 1'b1;
                        next_q.dq = {8'h00, cmd};
                        next_q.cnt = fir_pkg::WE_CYC;
                    end else begin
                        next_q.st = fir_pkg::S_RD;
                        next_q.oe_n = 1'b0;
                        next_q.cnt = fir_pkg::ACC_CYC;
                    end
                end
            end
            fir_pkg::S_CMD: begin
                next_q.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    next_q.we_n = 1'b1;
                    next_q.ce_n = 1'b1;
                    next_q.mode = q.tgt;
                    next_q.st = fir_pkg::S_CMD_GAP;
                    next_q.cnt = fir_pkg::GAP_CYC;
                end
            end
            fir_pkg::S_CMD_GAP: begin
                next_q.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    next_q.dq_oe = 1'b0;
                    if (q.need_rd) begin
                        next_q.st = fir_pkg::S_RD;
                        next_q.ce_n = 1'b0;
                        next_q.oe_n = 1'b0;
                        next_q.cnt = fir_pkg::ACC_CYC;
                    end else begin
                        next_q.st = fir_pkg::S_IDLE;
                    end
                end
            end
            fir_pkg::S_RD: begin
                next_q.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    next_q.result = dq_sync;
                    // Query data sit on the low byte only
                    if (q.op == fir_pkg::OP_QUERY_READ || !q.word) begin
                        next_q.result = {8'h00, dq_sync[7:0]};
                    end
                    if (q.op == fir_pkg::OP_STATUS_READ) begin
                        next_q.sr = dq_sync[7:0];
                    end
                    if (q.op == fir_pkg::OP_BLOCK_READ) begin
                        next_q.blk_valid = q.sr[fir_pkg::READY_BIT];
                    end
                    // Enables rise so the next read relatches status
                    next_q.oe_n = 1'b1;
                    next_q.ce_n = 1'b1;
                    next_q.st = fir_pkg::S_RD_GAP;
                    next_q.cnt = fir_pkg::GAP_CYC;
                end
            end
            fir_pkg::S_RD_GAP: begin
                next_q.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    next_q.st = fir_pkg::S_IDLE;
                end
            end
            default: next_q.st = fir_pkg::S_IDLE;
        endcase
        // Deep power-down drops the flash to array reads, so the mirror follows
        if (!q.rp) next_q.mode = fir_pkg::MODE_ARRAY;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.rp <= fir_pkg::CTRL_RESET[fir_pkg::CTRL_RP_BIT];
            q.word <= fir_pkg::CTRL_RESET[fir_pkg::CTRL_WORD_BIT];
            q.ce_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.we_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Pins and bus outputs straight from flops
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign flash_addr_o = q.pin_addr;
    assign flash_dq_o = q.dq;
    assign flash_dq_oe_o = q.dq_oe;
    assign flash_ce_n_o = q.ce_n;
    assign flash_oe_n_o = q.oe_n;
    assign flash_we_n_o = q.we_n;
    assign reset_powerdown_bar_o = q.rp;
    assign word_mode_o = q.word;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_mode_by_command: assert property (
        !$stable(q.mode) |-> ($past(q.st) == fir_pkg::S_CMD && $past(q.cnt) == 8'h01)
            || (!$past(q.rp) && q.mode == fir_pkg::MODE_ARRAY)
    ) else $error("read mode changed without a command write");

    chk_block_needs_ready: assert property (
        $rose(q.blk_valid) |-> q.sr[fir_pkg::READY_BIT] && $past(q.op) == fir_pkg::OP_BLOCK_READ
    ) else $error("block status marked valid without ready flag");

    chk_oe_gap: assert property (
        $rose(flash_oe_n_o) |-> flash_oe_n_o [*8]
    ) else $error("output enable not held high between reads");

    chk_ext_rewrite: assert property (
        $fell(flash_oe_n_o) && q.op == fir_pkg::OP_EXT_READ
        |-> $past(q.st) == fir_pkg::S_CMD_GAP && q.mode == fir_pkg::MODE_EXT
    ) else $error("extended status read without fresh command");

    chk_rp_high: assert property (
        $fell(flash_ce_n_o) |-> reset_powerdown_bar_o
    ) else $error("flash cycle started with reset pin low");

endmodule : fir_host

// File: common/fir_pkg.sv
// Shared constants and types for the flash information-read controller
package fir_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WE_PULSE_NS = 50;
    localparam int T_ACCESS_NS = 100;
    localparam int T_RECOVER_NS = 30;
    localparam logic [7:0] WE_CYC = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2);
    localparam logic [7:0] GAP_CYC = 8'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Flash command bytes and layout
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_MULTI_WRITE = 8'hE8;
    localparam logic [15:0] ID_BLOCK_OFS = 16'h0004;
    localparam int READY_BIT = 7;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Controller registers (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OP = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_RP_BIT = 0;
    localparam int CTRL_WORD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    typedef enum logic [2:0] {
        MODE_ARRAY = 3'h0,
        MODE_ID = 3'h1,
        MODE_STATUS = 3'h2,
        MODE_EXT = 3'h3,
        MODE_QUERY = 3'h4
    } fir_mode_t;

    typedef enum logic [2:0] {
        OP_ARRAY_READ = 3'h0,
        OP_ID_READ = 3'h1,
        OP_STATUS_READ = 3'h2,
        OP_EXT_READ = 3'h3,
        OP_CLEAR = 3'h4,
        OP_QUERY_READ = 3'h5,
        OP_BLOCK_READ = 3'h6,
        OP_RESET_ARRAY = 3'h7
    } fir_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CMD = 3'h1,
        S_CMD_GAP = 3'h2,
        S_RD = 3'h3,
        S_RD_GAP = 3'h4
    } fir_state_t;

endpackage : fir_pkg

// File: logic/fir_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module fir_sync #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;

    // ------------------------------------------------------------
    // One flop pair per bit
    // ------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                meta[i] <= 1'b0;
                stable[i] <= 1'b0;
            end else begin
                meta[i] <= d_i[i];
                stable[i] <= meta[i];
            end
        end
    end

    assign q_o = stable;
endmodule : fir_sync

// File: verif/fir_flash_model.sv
// Behavioural model of the flash information-read logic seen from its pins
`timescale 1ns/1ps
module fir_flash_model #(
    parameter logic [15:0] MFR_CODE = 16'h0011, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h00C3 // Arbitrary value
) (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rp_i,
    input wire logic word_i,
    input wire logic ready_i,
    input wire logic [20:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic [3:0] fail_i,
    input wire logic [31:0] lock_i,
    input wire logic [31:0] efail_i,
    input wire logic [7:0] xsr_i,
    output logic [15:0] dq_o
);
    logic [2:0] mode = 3'h0;
    logic [3:0] flg = 4'h0;
    logic [7:0] sr_now;
    logic [7:0] sr_lat = 8'h00;
    logic [7:0] xsr_lat = 8'h00;
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    logic [4:0] blk;

    // Command decode on the rising write strobe
    always @(posedge we_n_i) begin
        if (rp_i) begin
            case (dq_i[7:0])
                8'hFF: mode = 3'h0;
                8'h90: mode = 3'h1;
                8'h70: mode = 3'h2;
                8'hE8: begin
                    mode = 3'h3;
                    xsr_lat = xsr_i;
                end
                8'h98: mode = 3'h4;
                8'h50: if (ready_i) flg = 4'h0;
                default: ;
            endcase
        end
    end

    // Deep power-down falls back to array reads
    always @(negedge rp_i) mode = 3'h0;
    // Failure flags stay set until cleared
    always @(fail_i) flg = flg | fail_i;
    assign sr_now = {ready_i, 1'b0, flg[3:1], 1'b0, flg[0], 1'b0};
    // Status captured when either enable falls
    always @(negedge oe_n_i or negedge ce_n_i) sr_lat = sr_now;
    always @(posedge oe_n_i) last = rd;
    assign blk = addr_i[20:16];

    // Read data source follows the current mode
    always @* begin
        case (mode)
            3'h1: case (addr_i[15:0])
                16'h0000, 16'h0001: rd = MFR_CODE;
                16'h0002, 16'h0003: rd = DEV_CODE;
                16'h0004, 16'h0005: rd = {14'h0000, efail_i[blk], lock_i[blk]};
                default: rd = 16'h0000;
            endcase
            3'h2: rd = {8'h00, sr_lat};
            3'h3: rd = {8'h00, xsr_lat};
            3'h4: case (addr_i[8:1])
                8'h10: rd = 16'h0051;
                8'h11: rd = 16'h0052;
                8'h12: rd = 16'h0059;
                default: rd = 16'h0000;
            endcase
            default: rd = addr_i[15:0] ^ 16'h5A3C;
        endcase
        if (!word_i) rd[15:8] = ~last[15:8];
    end

    // Released bus shows no stale value
    assign dq_o = (!ce_n_i && !oe_n_i && rp_i) ? rd : ~last;
endmodule : fir_flash_model

// File: verif/tb_fir_host.sv
// Self-checking testbench for the flash information-read controller
`timescale 1ns/1ps
module tb_fir_host;
    localparam logic [15:0] MFR = 16'h0011; // Arbitrary value
    localparam logic [15:0] DEV = 16'h00C3; // Arbitrary value
    typedef struct packed {
        logic [2:0] op;
        logic [20:0] adr;
        logic [15:0] res;
        logic [2:0] mode;
    } fir_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ready = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [7:0] xsr = 8'h81;
    logic [3:0] fail = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, rd, st;
    logic ack, dq_oe, ce_n, oe_n, we_n, rp, word;
    logic [20:0] fa;
    logic [15:0] fdq_o, mdq, fdq_i;
    int fail_count = 0, num_checks = 0, cycles = 0;
    fir_row_t rows [12];

    // ----------------------------------------
    // Design, flash model and shared data wire
    // ----------------------------------------
    fir_host u_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .flash_addr_o(fa), .flash_dq_o(fdq_o), .flash_dq_oe_o(dq_oe),
        .flash_dq_i(fdq_i), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .reset_powerdown_bar_o(rp), .word_mode_o(word));
    fir_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .rp_i(rp), .word_i(word), .ready_i(ready), .addr_i(fa), .dq_i(fdq_i),
        .fail_i(fail), .lock_i(32'h0000_0004), .efail_i(32'h0000_0020), .xsr_i(xsr),
        .dq_o(mdq));
    assign fdq_i = dq_oe ? fdq_o : mdq;

    // Clock and hang guard
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) fail_count++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Start an operation, poll busy, fetch the result
    task automatic run_op(input logic [2:0] op, input logic [20:0] a);
        int n;
        n = 0;
        wb(1'b1, fir_pkg::REG_ADDR, {11'h000, a}, rd);
        wb(1'b1, fir_pkg::REG_OP, {29'h0, op}, rd);
        st = 32'h1;
        while (st[0] !== 1'b0 && n < 200) begin
            wb(1'b0, fir_pkg::REG_STATUS, 32'h0, st);
            n++;
        end
        if (n == 200) fail_count++;
        wb(1'b0, fir_pkg::REG_RESULT, 32'h0, rd);
    endtask : run_op

    task automatic op_chk(input logic [2:0] op, input logic [20:0] a, input logic [31:0] exp);
        run_op(op, a);
        check("op result", rd, exp);
    endtask : op_chk

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{fir_pkg::OP_ID_READ, 21'h0, MFR, fir_pkg::MODE_ID};
        rows[1] = '{fir_pkg::OP_ID_READ, 21'h3, DEV, fir_pkg::MODE_ID};
        rows[2] = '{fir_pkg::OP_BLOCK_READ, 21'h2, 16'h0001, fir_pkg::MODE_ID};
        rows[3] = '{fir_pkg::OP_BLOCK_READ, 21'h5, 16'h0002, fir_pkg::MODE_ID};
        rows[4] = '{fir_pkg::OP_STATUS_READ, 21'h0, 16'h0080, fir_pkg::MODE_STATUS};
        rows[5] = '{fir_pkg::OP_EXT_READ, 21'h0, 16'h0081, fir_pkg::MODE_EXT};
        rows[6] = '{fir_pkg::OP_QUERY_READ, 21'h10, 16'h0051, fir_pkg::MODE_QUERY};
        rows[7] = '{fir_pkg::OP_QUERY_READ, 21'h11, 16'h0052, fir_pkg::MODE_QUERY};
        rows[8] = '{fir_pkg::OP_QUERY_READ, 21'h5, 16'h0000, fir_pkg::MODE_QUERY};
        rows[9] = '{fir_pkg::OP_ARRAY_READ, 21'h120, 16'h5B1C, fir_pkg::MODE_ARRAY};
        rows[10] = '{fir_pkg::OP_ID_READ, 21'h1, MFR, fir_pkg::MODE_ID};
        rows[11] = '{fir_pkg::OP_RESET_ARRAY, 21'h0, 16'h0000, fir_pkg::MODE_ARRAY};
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        check("idle pins", {28'h0, ce_n, oe_n, we_n, rp}, 32'hF);
        wb(1'b0, fir_pkg::REG_CTRL, 32'h0, rd);
        check("ctrl reset", rd, {30'h0, fir_pkg::CTRL_RESET});
        wb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
        wb(1'b0, 8'h1C, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        foreach (rows[i]) begin
            run_op(rows[i].op, rows[i].adr);
            if (rows[i].op != fir_pkg::OP_RESET_ARRAY) begin
                check("row result", rd, {16'h0, rows[i].res});
            end
            check("row mode", {29'h0, st[3:1]}, {29'h0, rows[i].mode});
        end
        // Sticky flags, clearing, and clearing while not ready
        fail <= 4'hF;
        @(posedge clk_i);
        fail <= 4'h0;
        op_chk(fir_pkg::OP_STATUS_READ, 21'h0, 32'h00BA);
        run_op(fir_pkg::OP_CLEAR, 21'h0);
        op_chk(fir_pkg::OP_STATUS_READ, 21'h0, 32'h0080);
        ready <= 1'b0;
        fail <= 4'h1;
        run_op(fir_pkg::OP_CLEAR, 21'h0);
        ready <= 1'b1;
        op_chk(fir_pkg::OP_STATUS_READ, 21'h0, 32'h0082);
        op_chk(fir_pkg::OP_BLOCK_READ, 21'h2, 32'h0001);
        check("blk valid", {31'h0, st[4]}, 32'h1);
        // Extended status refreshes only by a new command
        op_chk(fir_pkg::OP_EXT_READ, 21'h0, 32'h0081);
        xsr <= 8'h00;
        op_chk(fir_pkg::OP_EXT_READ, 21'h0, 32'h0000);
        // Byte-wide query read
        wb(1'b1, fir_pkg::REG_CTRL, 32'h1, rd);
        check("word pin", {31'h0, word}, 32'h0);
        op_chk(fir_pkg::OP_QUERY_READ, 21'h12, 32'h0059);
        wb(1'b1, fir_pkg::REG_CTRL, 32'h3, rd);
        op_chk(fir_pkg::OP_ID_READ, 21'h1, {16'h0, MFR});
        // Power-down refuses work and returns the device to array reads
        wb(1'b1, fir_pkg::REG_CTRL, 32'h2, rd);
        check("rp pin", {31'h0, rp}, 32'h0);
        wb(1'b1, fir_pkg::REG_OP, 32'h1, rd);
        wb(1'b0, fir_pkg::REG_STATUS, 32'h0, st);
        check("busy", {31'h0, st[0]}, 32'h0);
        check("pd mode", {29'h0, st[3:1]}, {29'h0, fir_pkg::MODE_ARRAY});
        wb(1'b1, fir_pkg::REG_CTRL, 32'h3, rd);
        op_chk(fir_pkg::OP_ID_READ, 21'h0, {16'h0, MFR});
        end_sim();
    end
endmodule : tb_fir_host
